// >>> logic/aprt_map.svh
// Summary of operation
// RL1: primary port data input gated by bit 7
// RL2: secondary frame sync source from bits 6-4
// RL3: secondary bit clock source from bits 3-1
// RL4: secondary input one source from bits 7-5
// RL5: secondary input two source from bits 4-2
// RL6: bit 7 chooses channel one analog or microphone
// RL7: bit 6 chooses channel two analog or microphone
// RL8: bit 5 swaps channel 1/2 capture edges
// RL9: bit 4 swaps channel 3/4 capture edges
// RL10: bits 3-2 pick pair A microphone pin
// RL11: bits 1-0 pick pair B microphone pin
// RL12: override maps pin 1A choice to data input
// RL13: bit 6 makes serial output pin bidirectional
// RL14: pin or register control powers converter down
// RL15: bit 0 lets multipin one drive gain
// RL16: reserved bits written zero, read zero
// RL17: software avoids reserved selector codes
// RL18: output selector code 5 carries primary data
// RL19: pins synchronised; code zero gives inactive level
`ifndef APRT_MAP_SVH
`define APRT_MAP_SVH
`define APRT_OFS_CLK_ROUTE 8'h11
`define APRT_OFS_DATA_ROUTE 8'h12
`define APRT_OFS_MIC_ROUTE 8'h13
`define APRT_OFS_EXTRAS 8'h14
`define APRT_RST_CLK_ROUTE 8'h80
`define APRT_RST_DATA_ROUTE 8'h00
`define APRT_RST_MIC_ROUTE 8'h00
`define APRT_RST_EXTRAS 8'h00
`define APRT_MASK_CLK_ROUTE 8'hFE
`define APRT_MASK_DATA_ROUTE 8'hFC
`define APRT_MASK_MIC_ROUTE 8'hFF
`define APRT_MASK_EXTRAS 8'hF1
`define APRT_BIT_PRI_IN_EN 7
`define APRT_FS_HI 6
`define APRT_FS_LO 4
`define APRT_BC_HI 3
`define APRT_BC_LO 1
`define APRT_IN1_HI 7
`define APRT_IN1_LO 5
`define APRT_IN2_HI 4
`define APRT_IN2_LO 2
`define APRT_BIT_CH1_TYPE 7
`define APRT_BIT_CH2_TYPE 6
`define APRT_BIT_EDGE_A 5
`define APRT_BIT_EDGE_B 4
`define APRT_MA_HI 3
`define APRT_MA_LO 2
`define APRT_MB_HI 1
`define APRT_MB_LO 0
`define APRT_BIT_OVRD 7
`define APRT_BIT_OUT_WITH_IN 6
`define APRT_PD_HI 5
`define APRT_PD_LO 4
`define APRT_BIT_GAIN_EN 0
`define APRT_OUTSEL_PRIMARY 4'h5
`endif

// >>> logic/aprt_pkg.sv
package aprt_pkg;
   // 3-bit route codes of the secondary port selectors
   typedef enum logic [2:0] {
      APRT_R_OFF = 3'h0,
      APRT_R_MP1 = 3'h1,
      APRT_R_IN2A = 3'h2,
      APRT_R_IN1A = 3'h3,
      APRT_R_SOUT = 3'h4,
      APRT_R_PRI = 3'h5
   } aprt_route_t;
endpackage

// >>> logic/aprt_pin_routing.sv
`timescale 1ns/1ps
`include "aprt_map.svh"
module aprt_pin_routing
   import aprt_pkg::*;
(
   input wire logic CLK, // 40 MHz system clock
   input wire logic RESETN, // async reset, active low
   input wire logic REG_WR, // register write strobe
   input wire logic REG_RD, // register read strobe
   input wire logic [7:0] REG_ADDR, // register address
   input wire logic [7:0] REG_WDATA, // write data
   output logic [7:0] REG_RDATA, // read data, held after read
   input wire logic MULTIPIN_ONE, // multipin one pin
   input wire logic INPUT_PIN_TWO_A, // input pin 2A
   input wire logic INPUT_PIN_ONE_A, // input pin 1A
   input wire logic PRI_DATA_IN, // primary port data input pin
   input wire logic PRI_FSYNC, // primary port frame sync pin
   input wire logic PRI_BCLK, // primary port bit clock pin
   input wire logic SOUT_IN, // serial output pin, input side
   input wire logic [3:0] SOUT_FUNC_SEL, // serial output pin function selector
   input wire logic PRI_DATA_OUT, // primary port serial data from core
   input wire logic CONVERTER_POWERDOWN_CONTROL, // register power-down request, high = power down
   output logic PRI_PORT_DATA, // gated primary port data input
   output logic SEC_FSYNC, // secondary port frame sync
   output logic SEC_BCLK, // secondary port bit clock
   output logic SEC_DATA_ONE, // secondary port data input one
   output logic SEC_DATA_TWO, // secondary port data input two
   output logic SEC_PORT_ENABLE, // secondary port enabled
   output logic CH1_IS_MIC, // channel one is microphone type
   output logic CH2_IS_MIC, // channel two is microphone type
   output logic MIC_A_CH1_RISE, // channel one captured on rising edge
   output logic MIC_B_CH3_RISE, // channel three captured on rising edge
   output logic MIC_A_DATA, // microphone pair A data
   output logic MIC_A_ENABLE, // pair A enabled
   output logic MIC_B_DATA, // microphone pair B data
   output logic MIC_B_ENABLE, // pair B enabled
   output logic SOUT_OUT, // serial output pin drive value
   output logic SOUT_OE, // serial output pin enable
   output logic CONVERTER_POWERDOWN, // converter power down
   output logic GAIN_ADJUST_PIN, // gain adjust control from pin
   output logic GAIN_ADJUST_ENABLE // gain adjust pin control active
);

   ////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers

   logic [1:0] rst_sync_r; // reset release pipeline
   logic rst_n; // synchronised reset
   logic [6:0] meta_r; // first synchroniser stage, read only by sync_r
   logic [6:0] sync_r; // second stage, safe to use

   // release is synchronous so all flops leave reset on the same edge
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // every pin passes two flops before use; with the output stage a pin reaches an output three cycles later
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= 7'h00;
         sync_r <= 7'h00;
      end
      else
      begin
         meta_r <= {SOUT_IN, PRI_BCLK, PRI_FSYNC, PRI_DATA_IN,
                    INPUT_PIN_ONE_A, INPUT_PIN_TWO_A, MULTIPIN_ONE}; // [RL19]
         sync_r <= meta_r;
      end
   end

   // synchronised copies of the pins, plus the register request pdctl_s taken as is
   logic mp1_s; // multipin one
   logic in2a_s; // input pin 2A
   logic in1a_s; // input pin 1A
   logic pdin_s; // primary data input
   logic pfs_s; // primary frame sync
   logic pbc_s; // primary bit clock
   logic sout_s; // serial output pin, input side
   logic pdctl_s; // register power-down request

   assign {sout_s, pbc_s, pfs_s, pdin_s, in1a_s, in2a_s, mp1_s} = sync_r;
   // the request comes from a register on this clock, so no synchroniser is needed
   assign pdctl_s = CONVERTER_POWERDOWN_CONTROL;

   ////////////////////////////////////////////////////////////////////////
   // registers

   logic [7:0] clk_route_r; // secondary_port_clock_route
   logic [7:0] data_route_r; // secondary_port_data_route
   logic [7:0] mic_route_r; // digital_mic_route
   logic [7:0] extras_r; // pin_function_extras

   // reserved bits are masked on write so they always read zero
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_route_r <= `APRT_RST_CLK_ROUTE;
         data_route_r <= `APRT_RST_DATA_ROUTE;
         mic_route_r <= `APRT_RST_MIC_ROUTE;
         extras_r <= `APRT_RST_EXTRAS;
      end
      else if (REG_WR)
      begin
         unique case (REG_ADDR)
            `APRT_OFS_CLK_ROUTE: clk_route_r <= REG_WDATA & `APRT_MASK_CLK_ROUTE; // [RL16]
            `APRT_OFS_DATA_ROUTE: data_route_r <= REG_WDATA & `APRT_MASK_DATA_ROUTE; // [RL16]
            `APRT_OFS_MIC_ROUTE: mic_route_r <= REG_WDATA & `APRT_MASK_MIC_ROUTE;
            `APRT_OFS_EXTRAS: extras_r <= REG_WDATA & `APRT_MASK_EXTRAS; // [RL16]
            default: ; // unmapped addresses ignore writes
         endcase
      end
   end

   // read data registered; unmapped addresses return zero
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         REG_RDATA <= 8'h00;
      else if (REG_RD)
      begin
         unique case (REG_ADDR)
            `APRT_OFS_CLK_ROUTE: REG_RDATA <= clk_route_r;
            `APRT_OFS_DATA_ROUTE: REG_RDATA <= data_route_r;
            `APRT_OFS_MIC_ROUTE: REG_RDATA <= mic_route_r;
            `APRT_OFS_EXTRAS: REG_RDATA <= extras_r;
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // selection helpers

   // 3-bit route; reserved codes give a quiet zero rather than garbage
   function automatic logic route3(input logic [2:0] code, input logic mp1, input logic in2a,
                                   input logic in1a, input logic sout, input logic pri);
      unique case (aprt_route_t'(code))
         APRT_R_MP1: route3 = mp1;
         APRT_R_IN2A: route3 = in2a;
         APRT_R_IN1A: route3 = in1a;
         APRT_R_SOUT: route3 = sout;
         APRT_R_PRI: route3 = pri;
         default: route3 = 1'b0; // off and reserved codes [RL17]
      endcase
   endfunction

   // 2-bit pin choice; pin 1A may be replaced by the data input pin
   function automatic logic route2(input logic [1:0] code, input logic ovrd, input logic mp1,
                                   input logic in2a, input logic in1a, input logic din);
      unique case (code)
         2'h1: route2 = mp1;
         2'h2: route2 = in2a;
         2'h3: route2 = ovrd ? din : in1a; // [RL12]
         default: route2 = 1'b0; // disabled selector stays low [RL19]
      endcase
   endfunction

   logic sout_bidir; // serial output pin also used as input
   logic sout_in_ok; // pin input side usable
   logic [2:0] fs_sel; // secondary frame sync selector
   logic [2:0] bc_sel; // secondary bit clock selector
   logic [2:0] in1_sel; // secondary data one selector
   logic [2:0] in2_sel; // secondary data two selector
   logic [1:0] mic_a_sel; // pair A pin choice
   logic [1:0] mic_b_sel; // pair B pin choice
   logic mic_ovrd; // pin 1A choice becomes the data input pin
   logic pri_in_en; // primary data input enable
   logic gain_en; // multipin one drives the gain function
   logic [1:0] pd_sel; // power-down pin choice
   logic pd_pin; // selected power-down pin level
   logic mic_a_pin; // level picked for pair A
   logic mic_b_pin; // level picked for pair B

   assign sout_bidir = extras_r[`APRT_BIT_OUT_WITH_IN];
   // input side only meaningful when the pin is not purely an output
   assign sout_in_ok = sout_bidir || (SOUT_FUNC_SEL != `APRT_OUTSEL_PRIMARY);
   assign fs_sel = clk_route_r[`APRT_FS_HI:`APRT_FS_LO];
   assign bc_sel = clk_route_r[`APRT_BC_HI:`APRT_BC_LO];
   assign in1_sel = data_route_r[`APRT_IN1_HI:`APRT_IN1_LO];
   assign in2_sel = data_route_r[`APRT_IN2_HI:`APRT_IN2_LO];
   assign pd_sel = extras_r[`APRT_PD_HI:`APRT_PD_LO];
   assign mic_a_sel = mic_route_r[`APRT_MA_HI:`APRT_MA_LO];
   assign mic_b_sel = mic_route_r[`APRT_MB_HI:`APRT_MB_LO];
   assign mic_ovrd = extras_r[`APRT_BIT_OVRD];
   assign pri_in_en = clk_route_r[`APRT_BIT_PRI_IN_EN];
   assign gain_en = extras_r[`APRT_BIT_GAIN_EN];
   // the override reaches the microphone selectors only
   assign mic_a_pin = route2(mic_a_sel, mic_ovrd, mp1_s, in2a_s, in1a_s, pdin_s); // [RL10] [RL12]
   assign mic_b_pin = route2(mic_b_sel, mic_ovrd, mp1_s, in2a_s, in1a_s, pdin_s); // [RL11] [RL12]
   // no override for power down, so pin 1A always means pin 1A
   assign pd_pin = route2(pd_sel, 1'b0, mp1_s, in2a_s, in1a_s, 1'b0);

   ////////////////////////////////////////////////////////////////////////
   // primary and secondary port routing

   // primary data gate; a cleared enable holds the port input low
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         PRI_PORT_DATA <= 1'b0;
      else
         PRI_PORT_DATA <= pdin_s & pri_in_en; // [RL1]
   end

   // secondary clocks; code 4 is reserved here, so the serial pin is not offered
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         SEC_FSYNC <= 1'b0;
         SEC_BCLK <= 1'b0;
      end
      else
      begin
         SEC_FSYNC <= route3(fs_sel, mp1_s, in2a_s, in1a_s, 1'b0, pfs_s); // [RL2]
         SEC_BCLK <= route3(bc_sel, mp1_s, in2a_s, in1a_s, 1'b0, pbc_s); // [RL3]
      end
   end

   // secondary data; the serial pin counts only while its input side is usable
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         SEC_DATA_ONE <= 1'b0;
         SEC_DATA_TWO <= 1'b0;
      end
      else
      begin
         SEC_DATA_ONE <= route3(in1_sel, mp1_s, in2a_s, in1a_s, sout_s & sout_in_ok, pdin_s); // [RL4]
         SEC_DATA_TWO <= route3(in2_sel, mp1_s, in2a_s, in1a_s, sout_s & sout_in_ok, pdin_s); // [RL5]
      end
   end

   // port runs only with both clock sources set; one alone would leave it half clocked
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         SEC_PORT_ENABLE <= 1'b0;
      else
         SEC_PORT_ENABLE <= (fs_sel != 3'h0) && (bc_sel != 3'h0); // [RL2] [RL3]
   end

   ////////////////////////////////////////////////////////////////////////
   // microphone routing and record channel type

   // record channel type; analog unless the bit asks for a microphone
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         CH1_IS_MIC <= 1'b0;
         CH2_IS_MIC <= 1'b0;
      end
      else
      begin
         CH1_IS_MIC <= mic_route_r[`APRT_BIT_CH1_TYPE]; // [RL6]
         CH2_IS_MIC <= mic_route_r[`APRT_BIT_CH2_TYPE]; // [RL7]
      end
   end

   // capture edges: 0 = ch1 falling / ch2 rising; 1 swaps them, same for ch3 / ch4
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         MIC_A_CH1_RISE <= 1'b0;
         MIC_B_CH3_RISE <= 1'b0;
      end
      else
      begin
         MIC_A_CH1_RISE <= mic_route_r[`APRT_BIT_EDGE_A]; // [RL8]
         MIC_B_CH3_RISE <= mic_route_r[`APRT_BIT_EDGE_B]; // [RL9]
      end
   end

   // pair A; a disabled pair sees a steady low
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         MIC_A_DATA <= 1'b0;
         MIC_A_ENABLE <= 1'b0;
      end
      else
      begin
         MIC_A_DATA <= mic_a_pin; // [RL10] [RL19]
         MIC_A_ENABLE <= mic_a_sel != 2'h0; // [RL10]
      end
   end

   // pair B; a disabled pair sees a steady low
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         MIC_B_DATA <= 1'b0;
         MIC_B_ENABLE <= 1'b0;
      end
      else
      begin
         MIC_B_DATA <= mic_b_pin; // [RL11] [RL19]
         MIC_B_ENABLE <= mic_b_sel != 2'h0; // [RL11]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial output pin, power down and gain adjust

   // shared use still drives the primary output; the input side is read alongside
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         SOUT_OUT <= 1'b0;
         SOUT_OE <= 1'b0;
      end
      else
      begin
         SOUT_OUT <= PRI_DATA_OUT; // [RL18]
         SOUT_OE <= sout_bidir || (SOUT_FUNC_SEL == `APRT_OUTSEL_PRIMARY); // [RL13] [RL18]
      end
   end

   // either source powers down; the pin cannot cancel a register request
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         CONVERTER_POWERDOWN <= 1'b0;
      else
         CONVERTER_POWERDOWN <= pd_pin | pdctl_s; // [RL14]
   end

   // gain adjust from multipin one, held low while pin control is off
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         GAIN_ADJUST_PIN <= 1'b0;
         GAIN_ADJUST_ENABLE <= 1'b0;
      end
      else
      begin
         GAIN_ADJUST_PIN <= mp1_s & gain_en; // [RL15]
         GAIN_ADJUST_ENABLE <= gain_en; // [RL15]
      end
   end

endmodule

// >>> verification/aprt_pin_routing_props.sv
`timescale 1ns/1ps
module aprt_pin_routing_props (
   input wire logic CLK, // clock
   input wire logic RESETN, // reset, active low
   input wire logic REG_RD, // read strobe
   input wire logic [7:0] REG_ADDR, // address
   input wire logic [7:0] REG_RDATA, // read data
   input wire logic MULTIPIN_ONE, // multipin one pin
   input wire logic PRI_DATA_IN, // primary data pin
   input wire logic [3:0] SOUT_FUNC_SEL, // serial pin function
   input wire logic PRI_DATA_OUT, // primary data from core
   input wire logic CONVERTER_POWERDOWN_CONTROL, // register power-down
   input wire logic PRI_PORT_DATA, // gated primary data
   input wire logic MIC_A_DATA, // pair a data
   input wire logic MIC_A_ENABLE, // pair a enable
   input wire logic MIC_B_DATA, // pair b data
   input wire logic MIC_B_ENABLE, // pair b enable
   input wire logic SOUT_OUT, // serial pin drive
   input wire logic SOUT_OE, // serial pin enable
   input wire logic CONVERTER_POWERDOWN, // power down
   input wire logic GAIN_ADJUST_PIN, // gain from pin
   input wire logic GAIN_ADJUST_ENABLE // gain pin control on
);
   logic [3:0] up_cnt; // edges since release
   logic ready; // pipelines past the reset shadow
   ////////////////////////////////////////////////////////////
   // history checks wait until the synchronisers hold real samples
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         up_cnt <= 4'h0;
      else if (up_cnt != 4'hF)
         up_cnt <= up_cnt + 4'h1;
   end
   assign ready = (up_cnt == 4'hF);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   ////////////////////////////////////////////////////////////
   a_rdata_holds: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (ready && $past(REG_RD) && ($past(REG_ADDR) < 8'h11 ||
      $past(REG_ADDR) > 8'h14) |-> REG_RDATA == 8'h00) else $error("unmapped read not zero");
   a_rsvd_bits_zero: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h12 |-> REG_RDATA[1:0] == 2'b00)
      else $error("reserved bits read nonzero");
   a_pri_gate: assert property (ready && PRI_PORT_DATA |-> $past(PRI_DATA_IN, 3))
      else $error("primary data high without pin");
   a_mic_idle: assert property ((MIC_A_ENABLE || !MIC_A_DATA) && (MIC_B_ENABLE || !MIC_B_DATA))
      else $error("disabled mic data active");
   a_pd_control: assert property (ready && $past(CONVERTER_POWERDOWN_CONTROL) |-> CONVERTER_POWERDOWN)
      else $error("power-down request ignored");
   a_gain_gated: assert property (GAIN_ADJUST_PIN |-> GAIN_ADJUST_ENABLE)
      else $error("gain pin active while disabled");
   a_gain_follow: assert property (ready && GAIN_ADJUST_ENABLE && $past(GAIN_ADJUST_ENABLE) |->
      GAIN_ADJUST_PIN == $past(MULTIPIN_ONE, 3)) else $error("gain pin not following");
   a_sout_func: assert property (ready && $past(SOUT_FUNC_SEL) == 4'h5 |-> SOUT_OE)
      else $error("serial pin not driven for primary data");
   a_sout_copy: assert property (ready |-> SOUT_OUT == $past(PRI_DATA_OUT))
      else $error("serial pin value wrong");
endmodule
bind aprt_pin_routing aprt_pin_routing_props u_props (.CLK, .RESETN, .REG_RD, .REG_ADDR, .REG_RDATA,
   .MULTIPIN_ONE, .PRI_DATA_IN, .SOUT_FUNC_SEL, .PRI_DATA_OUT, .CONVERTER_POWERDOWN_CONTROL, .PRI_PORT_DATA,
   .MIC_A_DATA, .MIC_A_ENABLE, .MIC_B_DATA, .MIC_B_ENABLE, .SOUT_OUT, .SOUT_OE, .CONVERTER_POWERDOWN,
   .GAIN_ADJUST_PIN, .GAIN_ADJUST_ENABLE);

// >>> verification/aprt_far_end.sv
`timescale 1ns/1ps
// host port pins and microphones; pins move 3 ns after the edge so the
// bench's own 2 ns updates of the pattern never race with them
module aprt_far_end (
   input wire logic CLK, // clock
   input wire logic [6:0] pv, // {sout, bclk, fsync, din, in1a, in2a, mp1}
   output logic MULTIPIN_ONE, // multipin one
   output logic INPUT_PIN_TWO_A, // pin 2a
   output logic INPUT_PIN_ONE_A, // pin 1a
   output logic PRI_DATA_IN, // primary data
   output logic PRI_FSYNC, // primary frame sync
   output logic PRI_BCLK, // primary bit clock
   output logic SOUT_IN // serial pin, input side
);
   always @(posedge CLK)
      #3 {SOUT_IN, PRI_BCLK, PRI_FSYNC, PRI_DATA_IN, INPUT_PIN_ONE_A, INPUT_PIN_TWO_A, MULTIPIN_ONE} = pv;
endmodule

// >>> verification/aprt_pin_routing_bench.sv
`timescale 1ns/1ps
module aprt_pin_routing_bench;
   logic CLK = 1'b0, RESETN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, PRI_DATA_OUT = 1'b0;
   logic CONVERTER_POWERDOWN_CONTROL = 1'b0;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, rd_val, REG_RDATA;
   logic [3:0] SOUT_FUNC_SEL = 4'h0;
   logic [6:0] pv = 7'h00; // pin pattern for the far end
   logic MULTIPIN_ONE, INPUT_PIN_TWO_A, INPUT_PIN_ONE_A, PRI_DATA_IN, PRI_FSYNC, PRI_BCLK, SOUT_IN;
   logic PRI_PORT_DATA, SEC_FSYNC, SEC_BCLK, SEC_DATA_ONE, SEC_DATA_TWO, SEC_PORT_ENABLE, CH1_IS_MIC, CH2_IS_MIC;
   logic MIC_A_CH1_RISE, MIC_B_CH3_RISE, MIC_A_DATA, MIC_A_ENABLE, MIC_B_DATA, MIC_B_ENABLE, SOUT_OUT, SOUT_OE;
   logic CONVERTER_POWERDOWN, GAIN_ADJUST_PIN, GAIN_ADJUST_ENABLE;
   int miscompares = 0, cmp_count = 0;
   always #12.5 CLK = ~CLK;
   always @(posedge CLK) #2 PRI_DATA_OUT = ~PRI_DATA_OUT;
   aprt_pin_routing uut (.CLK, .RESETN, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .MULTIPIN_ONE,
      .INPUT_PIN_TWO_A, .INPUT_PIN_ONE_A, .PRI_DATA_IN, .PRI_FSYNC, .PRI_BCLK, .SOUT_IN, .SOUT_FUNC_SEL,
      .PRI_DATA_OUT, .CONVERTER_POWERDOWN_CONTROL, .PRI_PORT_DATA, .SEC_FSYNC, .SEC_BCLK, .SEC_DATA_ONE,
      .SEC_DATA_TWO, .SEC_PORT_ENABLE, .CH1_IS_MIC, .CH2_IS_MIC, .MIC_A_CH1_RISE, .MIC_B_CH3_RISE, .MIC_A_DATA,
      .MIC_A_ENABLE, .MIC_B_DATA, .MIC_B_ENABLE, .SOUT_OUT, .SOUT_OE, .CONVERTER_POWERDOWN, .GAIN_ADJUST_PIN,
      .GAIN_ADJUST_ENABLE);
   aprt_far_end far (.CLK, .pv, .MULTIPIN_ONE, .INPUT_PIN_TWO_A, .INPUT_PIN_ONE_A, .PRI_DATA_IN, .PRI_FSYNC,
      .PRI_BCLK, .SOUT_IN);
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      #2 REG_WR = 1'b1;
      REG_ADDR = a;
      REG_WDATA = d;
      @(posedge CLK);
      #2 REG_WR = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      #2 REG_RD = 1'b1;
      REG_ADDR = a;
      @(posedge CLK);
      #2 REG_RD = 1'b0;
      rd_val = REG_RDATA;
   endtask
   // pins need two sync stages plus the output stage
   task automatic settle(input logic [6:0] v);
      @(posedge CLK);
      #2 pv = v;
      repeat (4) @(posedge CLK);
      #2;
   endtask
   function automatic logic route(input logic [2:0] c, input logic [6:0] v, input logic pri);
      case (c)
         3'h1: return v[0];
         3'h2: return v[1];
         3'h3: return v[2];
         3'h4: return v[6];
         3'h5: return pri;
         default: return 1'b0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] rv [4] = '{8'h80, 8'h00, 8'h00, 8'h00};
      logic [7:0] wv [4] = '{8'hDB, 8'hB7, 8'hFF, 8'hFF};
      logic [7:0] ev [4] = '{8'hDA, 8'hB4, 8'hFF, 8'hF1};
      for (int i = 0; i < 4; i++)
      begin
         rd(8'h11 + i[7:0]);
         chk("reset value", rd_val, rv[i]);
         wr(8'h11 + i[7:0], wv[i]);
         rd(8'h11 + i[7:0]);
         chk("masked read", rd_val, ev[i]);
         wr(8'h11 + i[7:0], rv[i]);
      end
      rd(8'h15);
      chk("unmapped read", rd_val, 8'h00);
      $display("registers test done");
   endtask
   task automatic t_sec();
      logic [2:0] cs [4] = '{3'h1, 3'h2, 3'h3, 3'h5}; // reserved codes 4, 6, 7 left out
      logic [6:0] v;
      foreach (cs[i])
      begin
         wr(8'h11, {1'b1, cs[i], cs[i], 1'b0});
         for (int k = 0; k < 2; k++)
         begin
            v = k ? 7'h2A : 7'h55;
            settle(v);
            chk("frame sync", SEC_FSYNC, route(cs[i], v, v[4]));
            chk("bit clock", SEC_BCLK, route(cs[i], v, v[5]));
            chk("port enable", SEC_PORT_ENABLE, 8'h01);
         end
      end
      wr(8'h11, 8'h80);
      settle(7'h7F);
      chk("port off", {SEC_PORT_ENABLE, SEC_FSYNC, SEC_BCLK}, 8'h00);
      $display("clock route test done");
   endtask
   task automatic t_data();
      logic [6:0] v;
      for (int c = 1; c < 6; c++)
      begin
         wr(8'h12, {c[2:0], 3'(6 - c), 2'b00});
         for (int k = 0; k < 2; k++)
         begin
            v = k ? 7'h2A : 7'h55;
            settle(v);
            chk("data one", SEC_DATA_ONE, route(c[2:0], v, v[3]));
            chk("data two", SEC_DATA_TWO, route(3'(6 - c), v, v[3]));
         end
      end
      $display("data route test done");
   endtask
   task automatic t_mic();
      logic [6:0] v;
      for (int c = 1; c < 4; c++)
      begin
         wr(8'h13, {4'hA, c[1:0], 2'(4 - c)});
         for (int k = 0; k < 2; k++)
         begin
            v = k ? 7'h2A : 7'h55;
            settle(v);
            chk("type and edge", {CH1_IS_MIC, CH2_IS_MIC, MIC_A_CH1_RISE, MIC_B_CH3_RISE}, 8'h0A);
            chk("pair a", {MIC_A_ENABLE, MIC_A_DATA}, {6'h00, 1'b1, route(c[2:0], v, 1'b0)});
            chk("pair b", {MIC_B_ENABLE, MIC_B_DATA}, {6'h00, 1'b1, route(3'(4 - c), v, 1'b0)});
         end
      end
      wr(8'h14, 8'h80);
      wr(8'h13, 8'h5F);
      settle(7'h0B);
      chk("override", {CH2_IS_MIC, MIC_B_CH3_RISE, MIC_A_DATA, MIC_B_DATA}, 8'h0F);
      wr(8'h14, 8'h00);
      wr(8'h13, 8'h00);
      settle(7'h7F);
      chk("mic off", {CH1_IS_MIC, MIC_A_CH1_RISE, MIC_A_ENABLE, MIC_A_DATA, MIC_B_ENABLE}, 8'h00);
      $display("microphone test done");
   endtask
   task automatic t_extras();
      logic [6:0] v;
      wr(8'h14, 8'h40);
      settle(7'h00);
      chk("shared pin on", SOUT_OE, 8'h01);
      wr(8'h14, 8'h00);
      settle(7'h00);
      chk("shared pin off", SOUT_OE, 8'h00);
      wr(8'h12, 8'h80);
      SOUT_FUNC_SEL = 4'h5;
      settle(7'h7F);
      chk("primary out", SOUT_OE, 8'h01);
      chk("serial in blocked", SEC_DATA_ONE, 8'h00);
      SOUT_FUNC_SEL = 4'h0;
      for (int c = 1; c < 4; c++)
      begin
         wr(8'h14, {2'b00, c[1:0], 4'h1});
         for (int k = 0; k < 2; k++)
         begin
            v = k ? 7'h2A : 7'h55;
            settle(v);
            chk("pin power down", CONVERTER_POWERDOWN, route(c[2:0], v, 1'b0));
            chk("gain", {GAIN_ADJUST_ENABLE, GAIN_ADJUST_PIN}, {6'h00, 1'b1, v[0]});
         end
      end
      wr(8'h14, 8'h00);
      CONVERTER_POWERDOWN_CONTROL = 1'b1;
      settle(7'h7F);
      chk("reg power down", {CONVERTER_POWERDOWN, GAIN_ADJUST_PIN}, 8'h02);
      CONVERTER_POWERDOWN_CONTROL = 1'b0;
      chk("primary in on", PRI_PORT_DATA, 8'h01);
      wr(8'h11, 8'h00);
      settle(7'h7F);
      chk("primary in off", PRI_PORT_DATA, 8'h00);
      $display("extras test done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge CLK);
      #2 RESETN = 1'b1;
      repeat (3) @(posedge CLK);
      t_regs();
      t_sec();
      t_data();
      t_mic();
      t_extras();
      report_and_stop();
   end
   // the tests need well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge CLK);
      miscompares++;
      report_and_stop();
   end
endmodule
